// *** rtl/port_group.sv ***
`timescale 1ns/1ps
`default_nettype none

// How it works
// - port 2: eight input-only pins, read returns synchronised pin levels, analog shared
// - port 3: four bidirectional pins, latch, per-bit direction register
// - port 3 pull-up connects only in input mode with its option bit set
// - reset puts all bidirectional pins of ports 3-7, 12, 14 in input mode
// - port 4: eight directed pins with latch and per-bit pull-ups
// - expansion mode turns port 4 into the multiplexed address/data bus
// - port 5: eight directed pins, pull-ups, upper address bus in expansion mode
// - port 6 lower four pins are open-drain, never driving high
// - port 6 upper pull-ups by register; lower ones only a fixed mask option
// - expansion mode uses the upper port 6 pins for bus control signals
// - port 6 wait pin stays ordinary io unless external wait is used
// - port 7: eight directed pins, latch, input pull-ups, key return inputs
// - port 12: one bidirectional pin, pull-up, external interrupt input
// - port 13: one output-only pin driven from a cpu latch
// - port 13 drives low during reset; software may raise it afterward
// - port 14: six directed pins with latch, pull-ups and shared functions
// - direction bit 0 means output buffer on, 1 means input
// - reset loads all direction registers with ones

module port_group #(
   parameter logic [3:0] P6_MASK_PU_LOW = 4'h0
) (
   input  wire logic        i_clk_sys,
   input  wire logic        i_rst,
   // cpu access
   input  wire logic [3:0]  i_sel,
   input  wire logic        i_wr_latch,
   input  wire logic        i_wr_dir,
   input  wire logic        i_wr_pu,
   input  wire logic [7:0]  i_wdata,
   input  wire logic        i_rd,
   output logic      [7:0]  o_rdata,
   output logic             o_rd_valid,
   // expansion bus
   input  wire logic        i_ext_mode,
   input  wire logic        i_ext_wait_en,
   input  wire logic [7:0]  i_exp_ad_out,
   input  wire logic        i_exp_ad_drive,
   input  wire logic [7:0]  i_exp_addr_hi,
   input  wire logic        i_exp_rd_strobe,
   input  wire logic        i_exp_wr_strobe,
   input  wire logic        i_exp_astb,
   output logic      [7:0]  o_exp_ad_in,
   output logic             o_exp_wait_in,
   // port 2
   input  wire logic [7:0]  i_p2_pin,
   output logic      [7:0]  o_p2_in,
   // port 3
   input  wire logic [3:0]  i_p3_pin,
   output logic      [3:0]  o_p3_out,
   output logic      [3:0]  o_p3_oe_n,
   output logic      [3:0]  o_p3_pullup,
   output logic      [3:0]  o_p3_in,
   // port 4
   input  wire logic [7:0]  i_p4_pin,
   output logic      [7:0]  o_p4_out,
   output logic      [7:0]  o_p4_oe_n,
   output logic      [7:0]  o_p4_pullup,
   // port 5
   input  wire logic [7:0]  i_p5_pin,
   output logic      [7:0]  o_p5_out,
   output logic      [7:0]  o_p5_oe_n,
   output logic      [7:0]  o_p5_pullup,
   // port 6
   input  wire logic [7:0]  i_p6_pin,
   output logic      [7:0]  o_p6_out,
   output logic      [7:0]  o_p6_oe_n,
   output logic      [7:0]  o_p6_pullup,
   // port 7
   input  wire logic [7:0]  i_p7_pin,
   output logic      [7:0]  o_p7_out,
   output logic      [7:0]  o_p7_oe_n,
   output logic      [7:0]  o_p7_pullup,
   output logic      [7:0]  o_key_return,
   // port 12
   input  wire logic        i_p12_pin,
   output logic             o_p12_out,
   output logic             o_p12_oe_n,
   output logic             o_p12_pullup,
   output logic             o_p12_in,
   // port 13
   output logic             o_reset_mirror_out_pin,
   // port 14
   input  wire logic [5:0]  i_p14_pin,
   input  wire logic [5:0]  i_p14_alt_sel,
   input  wire logic [5:0]  i_p14_alt_out,
   input  wire logic [5:0]  i_p14_alt_drive,
   output logic      [5:0]  o_p14_out,
   output logic      [5:0]  o_p14_oe_n,
   output logic      [5:0]  o_p14_pullup,
   output logic      [5:0]  o_p14_in
);

   // ----------------------------------------------------------------
   // top-level state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] p2_meta_q;
      logic [7:0] p2_sync_q;
      logic       p13_latch_q;
      logic [7:0] rdata_q;
      logic       rd_valid_q;
   } top_state_t;

   top_state_t st_q;
   top_state_t st_d;

   // ----------------------------------------------------------------
   // write strobes per port
   // ----------------------------------------------------------------
   logic hit_p3;
   logic hit_p4;
   logic hit_p5;
   logic hit_p6;
   logic hit_p7;
   logic hit_p12;
   logic hit_p13;
   logic hit_p14;

   always_comb begin
      hit_p3  = 1'b0;
      hit_p4  = 1'b0;
      hit_p5  = 1'b0;
      hit_p6  = 1'b0;
      hit_p7  = 1'b0;
      hit_p12 = 1'b0;
      hit_p13 = 1'b0;
      hit_p14 = 1'b0;
      if (i_sel == port_group_pkg::SEL_P3) begin
         hit_p3 = 1'b1;
      end else if (i_sel == port_group_pkg::SEL_P4) begin
         hit_p4 = 1'b1;
      end else if (i_sel == port_group_pkg::SEL_P5) begin
         hit_p5 = 1'b1;
      end else if (i_sel == port_group_pkg::SEL_P6) begin
         hit_p6 = 1'b1;
      end else if (i_sel == port_group_pkg::SEL_P7) begin
         hit_p7 = 1'b1;
      end else if (i_sel == port_group_pkg::SEL_P12) begin
         hit_p12 = 1'b1;
      end else if (i_sel == port_group_pkg::SEL_P13) begin
         hit_p13 = 1'b1;
      end else if (i_sel == port_group_pkg::SEL_P14) begin
         hit_p14 = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // expansion-mode overrides
   // ----------------------------------------------------------------
   logic [7:0] p6_alt_sel;
   logic [7:0] p6_alt_out;
   logic [7:0] p6_alt_drive;
   logic       wait_used;

   assign wait_used = i_ext_mode & i_ext_wait_en;

   always_comb begin
      p6_alt_sel   = {8{i_ext_mode}} & port_group_pkg::P6_CTRL_MASK;
      p6_alt_sel[port_group_pkg::P6_WAIT_BIT] = wait_used;
      p6_alt_out   = 8'h00;
      p6_alt_out[4] = i_exp_rd_strobe;
      p6_alt_out[5] = i_exp_wr_strobe;
      p6_alt_out[7] = i_exp_astb;
      p6_alt_drive = port_group_pkg::P6_CTRL_MASK;
   end

   // ----------------------------------------------------------------
   // port slices
   // ----------------------------------------------------------------
   logic [3:0] p3_read;
   logic [7:0] p4_read;
   logic [7:0] p5_read;
   logic [7:0] p6_read;
   logic [7:0] p7_read;
   logic [0:0] p12_read;
   logic [5:0] p14_read;
   logic [7:0] p4_sync;
   logic [7:0] p6_sync;
   logic [7:0] p6_pu_sw;
   logic [0:0] p12_out;
   logic [0:0] p12_oe_n;
   logic [0:0] p12_pu;
   logic [0:0] p12_sync;

   gpio_port_slice #(.W(port_group_pkg::P3_W)) u_p3 (
      .i_clk_sys   (i_clk_sys),
      .i_rst       (i_rst),
      .i_wr_latch  (i_wr_latch & hit_p3),
      .i_wr_dir    (i_wr_dir & hit_p3),
      .i_wr_pu     (i_wr_pu & hit_p3),
      .i_wdata     (i_wdata[3:0]),
      .i_pin       (i_p3_pin),
      .i_alt_sel   (4'h0),
      .i_alt_out   (4'h0),
      .i_alt_drive (4'h0),
      .o_pin_out   (o_p3_out),
      .o_pin_oe_n  (o_p3_oe_n),
      .o_pullup    (o_p3_pullup),
      .o_pin_sync  (o_p3_in),
      .o_read      (p3_read)
   );

   gpio_port_slice #(.W(port_group_pkg::P4_W)) u_p4 (
      .i_clk_sys   (i_clk_sys),
      .i_rst       (i_rst),
      .i_wr_latch  (i_wr_latch & hit_p4),
      .i_wr_dir    (i_wr_dir & hit_p4),
      .i_wr_pu     (i_wr_pu & hit_p4),
      .i_wdata     (i_wdata),
      .i_pin       (i_p4_pin),
      .i_alt_sel   ({8{i_ext_mode}}),
      .i_alt_out   (i_exp_ad_out),
      .i_alt_drive ({8{i_exp_ad_drive}}),
      .o_pin_out   (o_p4_out),
      .o_pin_oe_n  (o_p4_oe_n),
      .o_pullup    (o_p4_pullup),
      .o_pin_sync  (p4_sync),
      .o_read      (p4_read)
   );

   gpio_port_slice #(.W(port_group_pkg::P5_W)) u_p5 (
      .i_clk_sys   (i_clk_sys),
      .i_rst       (i_rst),
      .i_wr_latch  (i_wr_latch & hit_p5),
      .i_wr_dir    (i_wr_dir & hit_p5),
      .i_wr_pu     (i_wr_pu & hit_p5),
      .i_wdata     (i_wdata),
      .i_pin       (i_p5_pin),
      .i_alt_sel   ({8{i_ext_mode}}),
      .i_alt_out   (i_exp_addr_hi),
      .i_alt_drive (8'hFF),
      .o_pin_out   (o_p5_out),
      .o_pin_oe_n  (o_p5_oe_n),
      .o_pullup    (o_p5_pullup),
      .o_pin_sync  (),
      .o_read      (p5_read)
   );

   gpio_port_slice #(
      .W       (port_group_pkg::P6_W),
      .OD_MASK (port_group_pkg::P6_OD_MASK),
      .PU_MASK (port_group_pkg::P6_PU_MASK)
   ) u_p6 (
      .i_clk_sys   (i_clk_sys),
      .i_rst       (i_rst),
      .i_wr_latch  (i_wr_latch & hit_p6),
      .i_wr_dir    (i_wr_dir & hit_p6),
      .i_wr_pu     (i_wr_pu & hit_p6),
      .i_wdata     (i_wdata),
      .i_pin       (i_p6_pin),
      .i_alt_sel   (p6_alt_sel),
      .i_alt_out   (p6_alt_out),
      .i_alt_drive (p6_alt_drive),
      .o_pin_out   (o_p6_out),
      .o_pin_oe_n  (o_p6_oe_n),
      .o_pullup    (p6_pu_sw),
      .o_pin_sync  (p6_sync),
      .o_read      (p6_read)
   );

   gpio_port_slice #(.W(port_group_pkg::P7_W)) u_p7 (
      .i_clk_sys   (i_clk_sys),
      .i_rst       (i_rst),
      .i_wr_latch  (i_wr_latch & hit_p7),
      .i_wr_dir    (i_wr_dir & hit_p7),
      .i_wr_pu     (i_wr_pu & hit_p7),
      .i_wdata     (i_wdata),
      .i_pin       (i_p7_pin),
      .i_alt_sel   (8'h00),
      .i_alt_out   (8'h00),
      .i_alt_drive (8'h00),
      .o_pin_out   (o_p7_out),
      .o_pin_oe_n  (o_p7_oe_n),
      .o_pullup    (o_p7_pullup),
      .o_pin_sync  (o_key_return),
      .o_read      (p7_read)
   );

   gpio_port_slice #(.W(port_group_pkg::P12_W)) u_p12 (
      .i_clk_sys   (i_clk_sys),
      .i_rst       (i_rst),
      .i_wr_latch  (i_wr_latch & hit_p12),
      .i_wr_dir    (i_wr_dir & hit_p12),
      .i_wr_pu     (i_wr_pu & hit_p12),
      .i_wdata     (i_wdata[0:0]),
      .i_pin       (i_p12_pin),
      .i_alt_sel   (1'b0),
      .i_alt_out   (1'b0),
      .i_alt_drive (1'b0),
      .o_pin_out   (p12_out),
      .o_pin_oe_n  (p12_oe_n),
      .o_pullup    (p12_pu),
      .o_pin_sync  (p12_sync),
      .o_read      (p12_read)
   );

   gpio_port_slice #(.W(port_group_pkg::P14_W)) u_p14 (
      .i_clk_sys   (i_clk_sys),
      .i_rst       (i_rst),
      .i_wr_latch  (i_wr_latch & hit_p14),
      .i_wr_dir    (i_wr_dir & hit_p14),
      .i_wr_pu     (i_wr_pu & hit_p14),
      .i_wdata     (i_wdata[5:0]),
      .i_pin       (i_p14_pin),
      .i_alt_sel   (i_p14_alt_sel),
      .i_alt_out   (i_p14_alt_out),
      .i_alt_drive (i_p14_alt_drive),
      .o_pin_out   (o_p14_out),
      .o_pin_oe_n  (o_p14_oe_n),
      .o_pullup    (o_p14_pullup),
      .o_pin_sync  (o_p14_in),
      .o_read      (p14_read)
   );

   // ----------------------------------------------------------------
   // port 2 sync, port 13 latch and read-back register
   // ----------------------------------------------------------------
   always_comb begin
      st_d            = st_q;
      st_d.p2_meta_q  = i_p2_pin;
      st_d.p2_sync_q  = st_q.p2_meta_q;
      st_d.rd_valid_q = i_rd;
      if (i_wr_latch && hit_p13) begin
         st_d.p13_latch_q = i_wdata[0];
      end
      if (i_rd) begin
         if (i_sel == port_group_pkg::SEL_P2) begin
            st_d.rdata_q = st_q.p2_sync_q;
         end else if (i_sel == port_group_pkg::SEL_P3) begin
            st_d.rdata_q = {4'h0, p3_read};
         end else if (i_sel == port_group_pkg::SEL_P4) begin
            st_d.rdata_q = p4_read;
         end else if (i_sel == port_group_pkg::SEL_P5) begin
            st_d.rdata_q = p5_read;
         end else if (i_sel == port_group_pkg::SEL_P6) begin
            st_d.rdata_q = p6_read;
         end else if (i_sel == port_group_pkg::SEL_P7) begin
            st_d.rdata_q = p7_read;
         end else if (i_sel == port_group_pkg::SEL_P12) begin
            st_d.rdata_q = {7'h00, p12_read};
         end else if (i_sel == port_group_pkg::SEL_P13) begin
            st_d.rdata_q = {7'h00, st_q.p13_latch_q};
         end else if (i_sel == port_group_pkg::SEL_P14) begin
            st_d.rdata_q = {2'h0, p14_read};
         end else begin
            st_d.rdata_q = 8'h00;
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         st_q.p2_meta_q   <= 8'h00;
         st_q.p2_sync_q   <= 8'h00;
         st_q.p13_latch_q <= port_group_pkg::P13_RST;
         st_q.rdata_q     <= 8'h00;
         st_q.rd_valid_q  <= 1'b0;
      end else begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // the pin is forced low while reset is asserted, not only after the edge
   assign o_reset_mirror_out_pin = st_q.p13_latch_q & ~i_rst;

   // lower port 6 pull-ups are fixed by the mask option parameter
   assign o_p6_pullup = {p6_pu_sw[7:4], P6_MASK_PU_LOW};

   assign o_p2_in       = st_q.p2_sync_q;
   assign o_p12_out     = p12_out[0];
   assign o_p12_oe_n    = p12_oe_n[0];
   assign o_p12_pullup  = p12_pu[0];
   assign o_p12_in      = p12_sync[0];
   assign o_exp_ad_in   = p4_sync;
   assign o_exp_wait_in = p6_sync[port_group_pkg::P6_WAIT_BIT] & wait_used;
   assign o_rdata       = st_q.rdata_q;
   assign o_rd_valid    = st_q.rd_valid_q;

endmodule : port_group

`default_nettype wire

// *** common/port_group_pkg.sv ***
package port_group_pkg;

   // ----------------------------------------------------------------
   // port widths
   // ----------------------------------------------------------------
   localparam int P2_W  = 8;
   localparam int P3_W  = 4;
   localparam int P4_W  = 8;
   localparam int P5_W  = 8;
   localparam int P6_W  = 8;
   localparam int P7_W  = 8;
   localparam int P12_W = 1;
   localparam int P14_W = 6;

   // ----------------------------------------------------------------
   // port select codes on the cpu access port
   // ----------------------------------------------------------------
   localparam logic [3:0] SEL_P2  = 4'h2;
   localparam logic [3:0] SEL_P3  = 4'h3;
   localparam logic [3:0] SEL_P4  = 4'h4;
   localparam logic [3:0] SEL_P5  = 4'h5;
   localparam logic [3:0] SEL_P6  = 4'h6;
   localparam logic [3:0] SEL_P7  = 4'h7;
   localparam logic [3:0] SEL_P12 = 4'hC;
   localparam logic [3:0] SEL_P13 = 4'hD;
   localparam logic [3:0] SEL_P14 = 4'hE;

   // ----------------------------------------------------------------
   // values after reset
   // ----------------------------------------------------------------
   localparam logic [7:0] DIR_RST   = 8'hFF;
   localparam logic [7:0] LATCH_RST = 8'h00;
   localparam logic [7:0] PU_RST    = 8'h00;
   localparam logic       P13_RST   = 1'b0;

   // ----------------------------------------------------------------
   // port 6 layout
   // ----------------------------------------------------------------
   localparam int          P6_WAIT_BIT = 6;
   localparam logic [7:0]  P6_OD_MASK  = 8'h0F;
   localparam logic [7:0]  P6_PU_MASK  = 8'hF0;
   localparam logic [7:0]  P6_CTRL_MASK = 8'hB0;

endpackage : port_group_pkg

// *** rtl/gpio_port_slice.sv ***
`timescale 1ns/1ps
`default_nettype none

module gpio_port_slice #(
   parameter int         W       = 8,
   parameter logic [7:0] OD_MASK = 8'h00,
   parameter logic [7:0] PU_MASK = 8'hFF
) (
   input  wire logic         i_clk_sys,
   input  wire logic         i_rst,
   input  wire logic         i_wr_latch,
   input  wire logic         i_wr_dir,
   input  wire logic         i_wr_pu,
   input  wire logic [W-1:0] i_wdata,
   input  wire logic [W-1:0] i_pin,
   input  wire logic [W-1:0] i_alt_sel,
   input  wire logic [W-1:0] i_alt_out,
   input  wire logic [W-1:0] i_alt_drive,
   output logic      [W-1:0] o_pin_out,
   output logic      [W-1:0] o_pin_oe_n,
   output logic      [W-1:0] o_pullup,
   output logic      [W-1:0] o_pin_sync,
   output logic      [W-1:0] o_read
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [W-1:0] latch_q;
      logic [W-1:0] dir_q;
      logic [W-1:0] pu_q;
      logic [W-1:0] meta_q;
      logic [W-1:0] sync_q;
   } slice_state_t;

   slice_state_t st_q;
   slice_state_t st_d;

   always_comb begin
      st_d        = st_q;
      st_d.meta_q = i_pin;
      st_d.sync_q = st_q.meta_q;
      if (i_wr_latch) begin
         st_d.latch_q = i_wdata;
      end
      if (i_wr_dir) begin
         st_d.dir_q = i_wdata;
      end
      if (i_wr_pu) begin
         st_d.pu_q = i_wdata & PU_MASK[W-1:0];
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         st_q.latch_q <= port_group_pkg::LATCH_RST[W-1:0];
         st_q.dir_q   <= port_group_pkg::DIR_RST[W-1:0];
         st_q.pu_q    <= port_group_pkg::PU_RST[W-1:0];
         st_q.meta_q  <= '0;
         st_q.sync_q  <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------------------------------
   // pin drive, pull-up and read-back per bit
   // ----------------------------------------------------------------
   genvar b;
   generate
      for (b = 0; b < W; b++) begin : g_bit
         logic drv;
         logic val;
         assign val = i_alt_sel[b] ? i_alt_out[b] : st_q.latch_q[b];
         assign drv = i_alt_sel[b] ? i_alt_drive[b] : ~st_q.dir_q[b];
         // open-drain bits only ever pull low
         assign o_pin_out[b]  = OD_MASK[b] ? 1'b0 : val;
         assign o_pin_oe_n[b] = OD_MASK[b] ? ~(drv & ~val) : ~drv;
         assign o_pullup[b]   = st_q.pu_q[b] & ~drv;
         assign o_read[b]     = st_q.dir_q[b] ? st_q.sync_q[b] : st_q.latch_q[b];
      end
   endgenerate

   assign o_pin_sync = st_q.sync_q;

endmodule : gpio_port_slice

`default_nettype wire

// *** bench/port_group_chk.sv ***
`timescale 1ns/1ps
`default_nettype none

module port_group_chk (
   input  wire logic       i_clk_sys,
   input  wire logic       i_rst,
   input  wire logic [3:0] i_sel,
   input  wire logic       i_wr_latch,
   input  wire logic       i_wr_dir,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_rd,
   input  wire logic       o_rd_valid,
   input  wire logic       i_ext_mode,
   input  wire logic       i_ext_wait_en,
   input  wire logic [7:0] i_exp_ad_out,
   input  wire logic       i_exp_ad_drive,
   input  wire logic [7:0] i_exp_addr_hi,
   input  wire logic       i_exp_rd_strobe,
   input  wire logic       i_exp_wr_strobe,
   input  wire logic       i_exp_astb,
   input  wire logic [3:0] o_p3_oe_n,
   input  wire logic [3:0] o_p3_pullup,
   input  wire logic [7:0] o_p4_out,
   input  wire logic [7:0] o_p4_oe_n,
   input  wire logic [7:0] o_p5_out,
   input  wire logic [7:0] o_p5_oe_n,
   input  wire logic [7:0] o_p6_out,
   input  wire logic [7:0] o_p6_oe_n,
   input  wire logic [7:0] o_p7_oe_n,
   input  wire logic [7:0] o_p7_pullup,
   input  wire logic       o_p12_oe_n,
   input  wire logic       o_reset_mirror_out_pin
);
   logic [7:0] wdata_q;
   always_ff @(posedge i_clk_sys) begin
      wdata_q <= i_wdata;
   end

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   sequence s_rd_req;
      i_rd;
   endsequence
   sequence s_rd_ans;
      o_rd_valid;
   endsequence

   a_rd_answer: assert property (s_rd_req |=> s_rd_ans) else $error("no read answer");
   a_rd_quiet: assert property (!i_rd |=> !o_rd_valid) else $error("stray read valid");
   a_rst_input: assert property ($past(i_rst) && !i_ext_mode |-> &o_p3_oe_n && &o_p4_oe_n && &o_p7_oe_n
      && o_p12_oe_n) else $error("pins not input after reset");
   a_mirror_rst: assert property (@(posedge i_clk_sys) disable iff (1'b0)
      i_rst |-> !o_reset_mirror_out_pin) else $error("port 13 high in reset");
   a_mirror_wr: assert property (i_wr_latch && i_sel == port_group_pkg::SEL_P13 |=>
      o_reset_mirror_out_pin == wdata_q[0]) else $error("p13 write lost");
   a_p3_dir: assert property (i_wr_dir && i_sel == port_group_pkg::SEL_P3 |=> o_p3_oe_n == wdata_q[3:0])
      else $error("port 3 direction wrong");
   a_pu_out_off: assert property ((o_p3_pullup & ~o_p3_oe_n) == 4'h0 && (o_p7_pullup & ~o_p7_oe_n) == 8'h00)
      else $error("pull-up on driven pin");
   a_p6_od: assert property (o_p6_out[3:0] == 4'h0) else $error("od pin high");
   a_exp_ad: assert property (i_ext_mode && i_exp_ad_drive |-> o_p4_oe_n == 8'h00 && o_p4_out == i_exp_ad_out)
      else $error("port 4 bus not driven");
   a_exp_addr: assert property (i_ext_mode |-> o_p5_oe_n == 8'h00 && o_p5_out == i_exp_addr_hi)
      else $error("p5 addr idle");
   a_exp_ctrl: assert property (i_ext_mode |-> (o_p6_oe_n & 8'hB0) == 8'h00 && o_p6_out[7] == i_exp_astb
      && o_p6_out[5] == i_exp_wr_strobe && o_p6_out[4] == i_exp_rd_strobe)
      else $error("bus control pins wrong");
   a_wait_in: assert property (i_ext_mode && i_ext_wait_en |-> o_p6_oe_n[6]) else $error("wait pin driven");
endmodule // port_group_chk

bind port_group port_group_chk chk_u (.*);

`default_nettype wire

// *** bench/pin_board_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module pin_board_model #(
   parameter int W = 8
) (
   input  wire logic [W-1:0] i_o,
   input  wire logic [W-1:0] i_oe_n,
   input  wire logic [W-1:0] i_pu,
   input  wire logic [W-1:0] i_bd,
   output logic      [W-1:0] o_pin
);
   assign o_pin = (~i_oe_n & i_o) | (i_oe_n & (i_pu | i_bd));
endmodule // pin_board_model

`default_nettype wire

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   localparam int LAT = 0, DIR = 1, PU = 2;
   localparam logic [3:0] S3 = port_group_pkg::SEL_P3, S6 = port_group_pkg::SEL_P6;

   logic       i_clk_sys = 1'b0, i_rst = 1'b1, i_wr_latch = 1'b0, i_wr_dir = 1'b0, i_wr_pu = 1'b0, i_rd = 1'b0;
   logic       i_ext_mode = 1'b0, i_ext_wait_en = 1'b0, i_exp_ad_drive = 1'b0, i_exp_rd_strobe = 1'b0;
   logic       i_exp_wr_strobe = 1'b0, i_exp_astb = 1'b0;
   logic [3:0] i_sel = 4'h0;
   logic [7:0] i_wdata = 8'h00, i_exp_ad_out = 8'h00, i_exp_addr_hi = 8'h00, i_p2_pin = 8'h00, board = 8'h00;
   logic [5:0] i_p14_alt_sel = 6'h00, i_p14_alt_out = 6'h00, i_p14_alt_drive = 6'h00;
   logic [7:0] o_rdata, o_exp_ad_in, o_p2_in, o_p4_out, o_p4_oe_n, o_p4_pullup, o_p5_out, o_p5_oe_n;
   logic [7:0] o_p5_pullup, o_p6_out, o_p6_oe_n, o_p6_pullup, o_p7_out, o_p7_oe_n, o_p7_pullup, o_key_return;
   logic [3:0] o_p3_out, o_p3_oe_n, o_p3_pullup, o_p3_in;
   logic [5:0] o_p14_out, o_p14_oe_n, o_p14_pullup, o_p14_in;
   logic       o_rd_valid, o_exp_wait_in, o_p12_out, o_p12_oe_n, o_p12_pullup, o_p12_in, o_reset_mirror_out_pin;
   wire logic [3:0] i_p3_pin;
   wire logic [7:0] i_p4_pin, i_p5_pin, i_p6_pin, i_p7_pin;
   wire logic       i_p12_pin;
   wire logic [5:0] i_p14_pin;
   int         error_cnt = 0;
   int         num_checks = 0;
   int         cyc = 0;
   logic [7:0] d;

   always #10 i_clk_sys = ~i_clk_sys;

   port_group dut_u (.*);
   pin_board_model #(.W(43)) pins_m (
      .i_o    ({o_p3_out, o_p4_out, o_p5_out, o_p6_out, o_p7_out, o_p12_out, o_p14_out}),
      .i_oe_n ({o_p3_oe_n, o_p4_oe_n, o_p5_oe_n, o_p6_oe_n, o_p7_oe_n, o_p12_oe_n, o_p14_oe_n}),
      .i_pu   ({o_p3_pullup, o_p4_pullup, o_p5_pullup, o_p6_pullup, o_p7_pullup, o_p12_pullup, o_p14_pullup}),
      .i_bd   ({board[3:0], {4{board}}, board[0], board[5:0]}),
      .o_pin  ({i_p3_pin, i_p4_pin, i_p5_pin, i_p6_pin, i_p7_pin, i_p12_pin, i_p14_pin})
   );

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wr(input int kind, input logic [3:0] sel, input logic [7:0] data);
      @(posedge i_clk_sys);
      i_sel <= sel;
      i_wdata <= data;
      i_wr_latch <= (kind == LAT);
      i_wr_dir <= (kind == DIR);
      i_wr_pu <= (kind == PU);
      @(posedge i_clk_sys);
      i_wr_latch <= 1'b0;
      i_wr_dir <= 1'b0;
      i_wr_pu <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [3:0] sel, output logic [7:0] data);
      @(posedge i_clk_sys);
      i_sel <= sel;
      i_rd <= 1'b1;
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
      #1;
      chk("rd_valid", 8'h01, {7'h00, o_rd_valid});
      data = o_rdata;
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic t_reset();
      #1;
      chk("p3_oe_n", 8'h0F, {4'h0, o_p3_oe_n});
      chk("p4_oe_n", 8'hFF, o_p4_oe_n);
      chk("p6_oe_n", 8'hFF, o_p6_oe_n);
      chk("p14_oe_n", 8'h3F, {2'b00, o_p14_oe_n});
      chk("p4_pullup", 8'h00, o_p4_pullup);
      chk("mirror", 8'h00, {7'h00, o_reset_mirror_out_pin});
   endtask

   task automatic t_p3();
      wr(PU, S3, 8'h0F);
      wr(LAT, S3, 8'h05);
      wr(DIR, S3, 8'h03);
      chk("p3_oe_n", 8'h03, {4'h0, o_p3_oe_n});
      chk("p3_pullup", 8'h03, {4'h0, o_p3_pullup});
      chk("p3_out", 8'h04, {4'h0, o_p3_out & ~o_p3_oe_n});
      repeat (3) @(posedge i_clk_sys);
      rd(S3, d);
      chk("p3_rd", 8'h07, d);
   endtask

   task automatic t_p2();
      @(posedge i_clk_sys);
      i_p2_pin <= 8'hA5;
      wr(LAT, port_group_pkg::SEL_P2, 8'h3C);
      repeat (3) @(posedge i_clk_sys);
      rd(port_group_pkg::SEL_P2, d);
      chk("p2_rd", 8'hA5, d);
      chk("p2_in", 8'hA5, o_p2_in);
   endtask

   task automatic t_p6();
      wr(LAT, S6, 8'hF5);
      wr(DIR, S6, 8'h00);
      chk("p6_oe_n", 8'h05, o_p6_oe_n);
      rd(S6, d);
      chk("p6_rd_out", 8'hF5, d);
      wr(DIR, S6, 8'hFF);
      wr(PU, S6, 8'hFF);
      chk("p6_pullup", 8'hF0, o_p6_pullup);
      @(posedge i_clk_sys);
      board <= 8'h0A;
      repeat (2) @(posedge i_clk_sys);
      rd(S6, d);
      chk("p6_rd_in", 8'hFA, d);
   endtask

   task automatic t_ports();
      logic [3:0] sel_tab [5];
      logic [7:0] msk_tab [5];
      sel_tab = '{port_group_pkg::SEL_P4, port_group_pkg::SEL_P5, port_group_pkg::SEL_P7, port_group_pkg::SEL_P12,
                  port_group_pkg::SEL_P14};
      msk_tab = '{8'hFF, 8'hFF, 8'hFF, 8'h01, 8'h3F};
      for (int k = 0; k < 5; k++) begin
         wr(LAT, sel_tab[k], 8'hA6);
         wr(DIR, sel_tab[k], 8'h00);
         wr(PU, sel_tab[k], 8'hFF);
         rd(sel_tab[k], d);
         chk("out_rd", 8'hA6 & msk_tab[k], d);
         wr(DIR, sel_tab[k], 8'hFF);
         repeat (3) @(posedge i_clk_sys);
         rd(sel_tab[k], d);
         chk("pullup_rd", msk_tab[k], d);
      end
      chk("key_return", 8'hFF, o_key_return);
   endtask

   task automatic t_ext();
      wr(DIR, S6, 8'hBF);
      @(posedge i_clk_sys);
      i_ext_mode <= 1'b1;
      i_ext_wait_en <= 1'b1;
      i_exp_ad_out <= 8'h5A;
      i_exp_ad_drive <= 1'b1;
      i_exp_addr_hi <= 8'hC3;
      i_exp_rd_strobe <= 1'b1;
      i_exp_wr_strobe <= 1'b1;
      i_exp_astb <= 1'b1;
      i_p14_alt_sel <= 6'h03;
      i_p14_alt_drive <= 6'h01;
      @(posedge i_clk_sys);
      #1;
      chk("p4_bus", 8'h5A, o_p4_out & ~o_p4_oe_n);
      chk("p5_addr", 8'hC3, o_p5_out & ~o_p5_oe_n);
      chk("p6_ctrl", 8'hB0, o_p6_out & 8'hB0);
      chk("wait", 8'h03, {6'h00, o_p6_oe_n[6], o_exp_wait_in});
      chk("p14_alt", 8'h3E, {2'h0, o_p14_oe_n});
      @(posedge i_clk_sys);
      i_ext_wait_en <= 1'b0;
      i_exp_ad_drive <= 1'b0;
      i_p14_alt_sel <= 6'h00;
      repeat (2) @(posedge i_clk_sys);
      #1;
      chk("wait_io", 8'h00, {6'h00, o_p6_oe_n[6], o_exp_wait_in});
      chk("ad_in", 8'hFF, o_exp_ad_in);
      i_ext_mode <= 1'b0;
   endtask

   task automatic t_p13();
      wr(LAT, port_group_pkg::SEL_P13, 8'h01);
      chk("mirror_hi", 8'h01, {7'h00, o_reset_mirror_out_pin});
      @(posedge i_clk_sys);
      i_rst <= 1'b1;
      repeat (2) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      #1;
      chk("mirror_rst", 8'h00, {7'h00, o_reset_mirror_out_pin});
      t_reset();
      wr(LAT, port_group_pkg::SEL_P13, 8'h01);
      chk("mirror_rel", 8'h01, {7'h00, o_reset_mirror_out_pin});
   endtask

   always @(posedge i_clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         error_cnt++;
         final_report();
      end
   end

   initial begin
      repeat (12) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      t_reset();
      t_p3();
      t_p2();
      t_p6();
      t_ports();
      t_ext();
      t_p13();
      final_report();
   end
endmodule // tb_top

`default_nettype wire
